//--- bench/rre_exec_bench.sv
// Self-checking bench: random register reference words run through whole phases.
// Assumes the executor, its package and the fetch partner model.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module rre_exec_bench;
  localparam logic [1:0] OK = rre_pkg::RRE_RESP_OKAY;
  localparam logic [1:0] ER = rre_pkg::RRE_RESP_SLVERR;
  logic        sys_clk, rst_n, go, start_phase, exec_busy;
  logic [15:0] word, fetch_word, mem_addr, w, a, b, pc;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, lfsr;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, e;
  logic [1:0]  bresp, rresp, bx;
  logic [33:0] rq[$], rx;
  logic [1:0]  bq[$];
  logic [17:0] r;
  logic [15:0] mq[$], mx;
  logic        bz;
  int          mismatches, n_tests;

  rre_fetch_model part (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .word(word),
    .start_phase(start_phase), .fetch_word(fetch_word));
  rre_exec dut (.sys_clk(sys_clk), .rst_n(rst_n), .start_phase(start_phase),
    .fetch_word(fetch_word), .exec_busy(exec_busy), .mem_addr(mem_addr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Returns the new extend bit above the shifted word
  function automatic logic [16:0] sh(input logic [2:0] op, input logic [15:0] v,
                                     input logic x);
    case (op)
      3'h0: sh = {x, v[15], v[13:0], 1'b0};
      3'h1: sh = {x, v[15], v[15:1]};
      3'h2: sh = {x, v[14:0], v[15]};
      3'h3: sh = {x, v[0], v[15:1]};
      3'h4: sh = {x, 1'b0, v[13:0], 1'b0};
      3'h5: sh = {v[0], x, v[15:1]};
      3'h6: sh = {v[15], v[14:0], x};
      default: sh = {x, v[11:0], v[15:12]};
    endcase
  endfunction

  // Whole phase on one accumulator: {skip, extend, accumulator}
  function automatic logic [17:0] ex(input logic [15:0] t, input logic [15:0] v,
                                     input logic x);
    logic s;
    s = 1'b0;
    if (t[15:12] == 4'h0 && !t[10])
    begin
      if (t[9]) {x, v} = sh(t[8:6], v, x);
      if (t[5]) x = 1'b0;
      if (t[3] && !v[0]) s = 1'b1;
      if (t[4]) {x, v} = sh(t[2:0], v, x);
    end
    else if (t[15:12] == 4'h0)
    begin
      if (t[5] && x == t[0]) s = 1'b1;
      case (t[9:8])
        2'h1: v = 16'h0000;
        2'h2: v = ~v;
        2'h3: v = 16'hFFFF;
        default: ;
      endcase
      case (t[7:6])
        2'h1: x = 1'b0;
        2'h2: x = ~x;
        2'h3: x = 1'b1;
        default: ;
      endcase
      if (t[4] && v[15] == t[0]) s = 1'b1;
      if (t[3] && v[0] == t[0]) s = 1'b1;
      if (t[2]) v = v + 16'h0001;
      if (t[1] && (|v) == t[0]) s = 1'b1;
    end
    return {s, x, v};
  endfunction

  task wr(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] rs);
    logic ta, tw;
    bq.push_back(rs);
    ta = 1'b0;
    tw = 1'b0;
    @(posedge sys_clk);
    awaddr <= ad;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (!ta && awready)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!(ta && tw));
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] rs);
    rq.push_back({rs, 16'h0000, d});
    @(posedge sys_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task run(input logic [15:0] t);
    @(posedge sys_clk);
    word <= t;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    do @(posedge sys_clk); while (!exec_busy);
    do @(posedge sys_clk); while (exec_busy);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    if (rvalid && rready)
    begin
      rx = rq.pop_front();
      `CHK({rresp, rdata}, rx)
    end
    if (bvalid && bready)
    begin
      bx = bq.pop_front();
      `CHK(bresp, bx)
    end
    // Memory address port checked as the phase ends
    if (bz && !exec_busy)
    begin
      mx = mq.pop_front();
      `CHK(mem_addr, mx)
    end
    bz = exec_busy;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    {sys_clk, rst_n, go, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {word, awaddr, araddr, wdata} = 64'h0;
    wstrb = 4'hF;
    lfsr = 32'h000023F9;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(8'(i * 4), 16'h0000, OK);
    wr(rre_pkg::RRE_OFS_MAR, 16'h1234, ER);
    wr(rre_pkg::RRE_OFS_STAT, 16'h1234, ER);
    wr(8'h18, 16'h1234, ER);
    rd(8'h18, 16'h0000, ER);
    for (int i = 0; i < 48; i++)
    begin
      w = {4'h0, lfsr[11:0]};
      if (i < 8) w[10:6] = {2'b01, 3'(i)};
      if (i == 8) w[15] = 1'b1;
      a = lfsr[31:16];
      lfsr = nx(lfsr);
      {pc, b} = lfsr;
      e = lfsr[7];
      lfsr = nx(lfsr);
      wr(rre_pkg::RRE_OFS_ACC_A, a, OK);
      wr(rre_pkg::RRE_OFS_ACC_B, b, OK);
      wr(rre_pkg::RRE_OFS_FLAGS, {15'h0, e}, OK);
      wr(rre_pkg::RRE_OFS_PC, pc, OK);
      r = ex(w, w[11] ? b : a, e);
      mq.push_back(pc + 16'h0001 + 16'(r[17]));
      run(w);
      rd(rre_pkg::RRE_OFS_ACC_A, w[11] ? a : r[15:0], OK);
      rd(rre_pkg::RRE_OFS_ACC_B, w[11] ? r[15:0] : b, OK);
      rd(rre_pkg::RRE_OFS_FLAGS, {14'h0, r[17:16]}, OK);
      rd(rre_pkg::RRE_OFS_PC, pc + 16'h0001 + 16'(r[17]), OK);
      rd(rre_pkg::RRE_OFS_MAR, pc + 16'h0001 + 16'(r[17]), OK);
    end
    @(posedge sys_clk);
    end_sim();
  end
endmodule

//--- bench/rre_fetch_model.sv
// Timing-side partner: raises the phase start and presents the fetched word.
// Assumes the bench asks for a phase only while the executor is idle.
`timescale 1ns/1ps
module rre_fetch_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Bench request
  input  wire logic        go,
  input  wire logic [15:0] word,
  // Executor side
  output logic             start_phase,
  output logic [15:0]      fetch_word
);
  logic [3:0] cnt_q;

  // Word held only through the fetch window, then the lines keep changing
  always_ff @(posedge sys_clk)
  begin
    start_phase <= go;
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      fetch_word <= 16'hFFFF;
    end
    else if (go)
    begin
      cnt_q <= 4'hA;
      fetch_word <= word;
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else
      fetch_word <= ~fetch_word;
  end
endmodule

//--- logic/rre_exec.sv
// Register reference executor: walks T0..T7 of one fetch phase.
// Assumes a start pulse and fetched word from timing logic on sys_clk.
// Functional notes
// (RL1) Accumulator work happens only in T3 to T5
// (RL2) T0-T2 clear registers, load upper six bits
// (RL3) T7 stores counter plus one plus skip
// (RL4) Shifts in T3/T5, extend clear and test T4
// (RL5) Arithmetic left keeps sign, zero fill
// (RL6) Arithmetic right replicates sign bit
// (RL7) Rotate left wraps bit 15 to 0
// (RL8) Rotate right wraps bit 0 to 15
// (RL9) Left shift clears sign and bit 0
// (RL10) Right rotate through extend, old lsb to extend
// (RL11) Left rotate through extend, old msb to extend
// (RL12) Four place left rotate wraps nibble
// (RL13) Bit 5 in T4 clears extend
// (RL14) Bit 3 in T4 skips on lsb zero
// (RL15) Alter and extend test T3, sign/lsb tests T4, increment then zero test
// (RL16) Alter stores, skip only sets carry
// (RL17) Clear passes zero buses through xor
// (RL18) Bit 11 picks accumulator A or B
// (RL19) Carry cleared at start of phase
// (RL20) Network combinational, store at period end
`timescale 1ns/1ps
module rre_exec (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Timing and fetch
  input  wire logic        start_phase,
  input  wire logic [15:0] fetch_word,
  output wire logic        exec_busy,
  output wire logic [15:0] mem_addr,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  rre_pkg::rre_state_t state_q, state_d;
  logic [15:0] acc_a_q, acc_a_d, acc_b_q, acc_b_d, pc_q, pc_d, mar_q, mar_d;
  logic [15:0] tr_q, tr_d;
  logic [5:0]  ir_q, ir_d;
  logic        ext_q, ext_d, carry_q, carry_d, busy_q, busy_d;
  logic [15:0] racc, acc_new, inc_val;
  logic        acc_wr, is_rr, grp_as;
  logic [15:0] zero_bus;
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0]  waddr_q, waddr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [1:0]  wstrb_q, wstrb_d, bresp_q, bresp_d, rresp_q, rresp_d;
  logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d, wr_do;
  logic [31:0] rdata_q, rdata_d;

  rre_shift_if sif ();

  rre_shift_net u_net (
    .sif (sif.net)
  );

  // Test result with reverse skip sense
  function automatic logic skip_hit(input logic tbit, input logic rss);
    skip_hit = (tbit == rss);
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == rre_pkg::RRE_OFS_ACC_A) || (a == rre_pkg::RRE_OFS_ACC_B) ||
             (a == rre_pkg::RRE_OFS_FLAGS) || (a == rre_pkg::RRE_OFS_PC) ||
             (a == rre_pkg::RRE_OFS_MAR) || (a == rre_pkg::RRE_OFS_STAT);
  endfunction

  assign zero_bus = rre_pkg::RRE_WORD_RST;
  assign racc     = tr_q[rre_pkg::RRE_TR_ACC_SEL] ? acc_b_q : acc_a_q; // see (RL18)
  assign is_rr    = (ir_q[rre_pkg::RRE_IR_TYPE_LO +: 4] == rre_pkg::RRE_IR_TYPE_RR);
  assign grp_as   = ir_q[rre_pkg::RRE_IR_GRP];
  assign inc_val  = tr_q[rre_pkg::RRE_AS_INC] ? racc + 16'h0001 : racc;

  always_comb
  begin
    sif.first_operand_bus = racc;
    sif.ext_in            = ext_q;
    if (state_q == rre_pkg::RRE_T3)
      sif.shift_op = rre_pkg::rre_shop_t'(tr_q[rre_pkg::RRE_SR_OP1_LO +: 3]);
    else
      sif.shift_op = rre_pkg::rre_shop_t'(tr_q[rre_pkg::RRE_SR_OP2_LO +: 3]);
  end

  // Phase sequencer and datapath
  always_comb
  begin
    state_d = state_q;
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    pc_d    = pc_q;
    mar_d   = mar_q;
    tr_d    = tr_q;
    ir_d    = ir_q;
    ext_d   = ext_q;
    carry_d = carry_q;
    acc_new = racc;
    acc_wr  = 1'b0;
    case (state_q)
      rre_pkg::RRE_IDLE:
      begin
        if (start_phase)
          state_d = rre_pkg::RRE_T0;
        if (wr_do && !busy_q)
        begin
          if (waddr_q == rre_pkg::RRE_OFS_ACC_A)
            acc_a_d = merge16(acc_a_q, wdata_q, wstrb_q);
          else if (waddr_q == rre_pkg::RRE_OFS_ACC_B)
            acc_b_d = merge16(acc_b_q, wdata_q, wstrb_q);
          else if (waddr_q == rre_pkg::RRE_OFS_PC)
            pc_d = merge16(pc_q, wdata_q, wstrb_q);
          else if (waddr_q == rre_pkg::RRE_OFS_FLAGS && wstrb_q[0])
            ext_d = wdata_q[rre_pkg::RRE_FLG_EXT];
        end
      end
      rre_pkg::RRE_T0:
      begin
        tr_d    = rre_pkg::RRE_WORD_RST; // see (RL2)
        ir_d    = rre_pkg::RRE_IR_RST;
        carry_d = rre_pkg::RRE_BIT_RST; // see (RL19)
        state_d = rre_pkg::RRE_T1;
      end
      rre_pkg::RRE_T1:
      begin
        tr_d    = fetch_word;
        state_d = rre_pkg::RRE_T2;
      end
      rre_pkg::RRE_T2:
      begin
        ir_d    = tr_q[rre_pkg::RRE_TR_IR_LO +: 6]; // see (RL2)
        state_d = rre_pkg::RRE_T3;
      end
      rre_pkg::RRE_T3:
      begin
        state_d = rre_pkg::RRE_T4;
        if (is_rr && !grp_as && tr_q[rre_pkg::RRE_SR_EN1])
        begin
          acc_new = sif.result_bus; // see (RL4) (RL20)
          acc_wr  = 1'b1;
          ext_d   = sif.ext_out; // see (RL10) (RL11)
        end
        else if (is_rr && grp_as)
        begin
          // Extend test looks at the value before its alteration
          if (tr_q[rre_pkg::RRE_AS_SEZ] && skip_hit(ext_q, tr_q[rre_pkg::RRE_AS_RSS]))
            carry_d = 1'b1; // see (RL16)
          case (tr_q[rre_pkg::RRE_AS_ACC_LO +: 2]) // see (RL15)
            rre_pkg::RRE_ALT_CLR:
            begin
              acc_new = zero_bus ^ zero_bus; // see (RL17)
              acc_wr  = 1'b1;
            end
            rre_pkg::RRE_ALT_CMP:
            begin
              acc_new = ~racc;
              acc_wr  = 1'b1;
            end
            rre_pkg::RRE_ALT_BOTH:
            begin
              acc_new = ~zero_bus;
              acc_wr  = 1'b1;
            end
            default:
              acc_wr  = 1'b0;
          endcase
          case (tr_q[rre_pkg::RRE_AS_EXT_LO +: 2])
            rre_pkg::RRE_ALT_CLR:  ext_d = 1'b0;
            rre_pkg::RRE_ALT_CMP:  ext_d = ~ext_q;
            rre_pkg::RRE_ALT_BOTH: ext_d = 1'b1;
            default:               ext_d = ext_q;
          endcase
        end
      end
      rre_pkg::RRE_T4:
      begin
        state_d = rre_pkg::RRE_T5;
        if (is_rr && !grp_as)
        begin
          if (tr_q[rre_pkg::RRE_SR_CLE])
            ext_d = 1'b0; // see (RL13) (RL4)
          if (tr_q[rre_pkg::RRE_SR_SLA] && !racc[0])
            carry_d = 1'b1; // see (RL14)
        end
        else if (is_rr && grp_as)
        begin
          if (tr_q[rre_pkg::RRE_AS_SSA] && skip_hit(racc[15], tr_q[rre_pkg::RRE_AS_RSS]))
            carry_d = 1'b1; // see (RL15)
          if (tr_q[rre_pkg::RRE_AS_SLA] && skip_hit(racc[0], tr_q[rre_pkg::RRE_AS_RSS]))
            carry_d = 1'b1;
        end
      end
      rre_pkg::RRE_T5:
      begin
        state_d = rre_pkg::RRE_T6;
        if (is_rr && !grp_as && tr_q[rre_pkg::RRE_SR_EN2])
        begin
          acc_new = sif.result_bus; // see (RL4)
          acc_wr  = 1'b1;
          ext_d   = sif.ext_out;
        end
        else if (is_rr && grp_as)
        begin
          acc_new = inc_val; // see (RL15)
          acc_wr  = tr_q[rre_pkg::RRE_AS_INC];
          if (tr_q[rre_pkg::RRE_AS_SZA] && skip_hit(|inc_val, tr_q[rre_pkg::RRE_AS_RSS]))
            carry_d = 1'b1; // see (RL16)
        end
      end
      rre_pkg::RRE_T6:
        state_d = rre_pkg::RRE_T7;
      rre_pkg::RRE_T7:
      begin
        pc_d    = pc_q + 16'h0001 + {15'h0, carry_q}; // see (RL3)
        mar_d   = pc_q + 16'h0001 + {15'h0, carry_q};
        state_d = rre_pkg::RRE_IDLE;
      end
      default:
        state_d = rre_pkg::RRE_IDLE;
    endcase
    if (acc_wr && tr_q[rre_pkg::RRE_TR_ACC_SEL])
      acc_b_d = acc_new; // see (RL18) (RL1)
    else if (acc_wr)
      acc_a_d = acc_new;
    busy_d = (state_d != rre_pkg::RRE_IDLE);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= rre_pkg::RRE_IDLE;
      acc_a_q <= rre_pkg::RRE_WORD_RST;
      acc_b_q <= rre_pkg::RRE_WORD_RST;
      pc_q    <= rre_pkg::RRE_WORD_RST;
      mar_q   <= rre_pkg::RRE_WORD_RST;
      tr_q    <= rre_pkg::RRE_WORD_RST;
      ir_q    <= rre_pkg::RRE_IR_RST;
      ext_q   <= rre_pkg::RRE_BIT_RST;
      carry_q <= rre_pkg::RRE_BIT_RST;
      busy_q  <= rre_pkg::RRE_BIT_RST;
    end
    else
    begin
      state_q <= state_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      pc_q    <= pc_d;
      mar_q   <= mar_d;
      tr_q    <= tr_d;
      ir_q    <= ir_d;
      ext_q   <= ext_d;
      carry_q <= carry_d;
      busy_q  <= busy_d;
    end
  end

  // AXI4-Lite slave
  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    wr_do     = aw_full_q && w_full_q && !bvalid_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_full_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata[15:0];
      wstrb_d  = s_axi_wstrb[1:0];
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (wr_do)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      // Writes while a phase runs, to read-only or unmapped words, are refused
      if (mapped(waddr_q) && !busy_q && waddr_q != rre_pkg::RRE_OFS_MAR &&
          waddr_q != rre_pkg::RRE_OFS_STAT)
        bresp_d = rre_pkg::RRE_RESP_OKAY;
      else
        bresp_d = rre_pkg::RRE_RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? rre_pkg::RRE_RESP_OKAY : rre_pkg::RRE_RESP_SLVERR;
      if (s_axi_araddr == rre_pkg::RRE_OFS_ACC_A)
        rdata_d = {16'h0000, acc_a_q};
      else if (s_axi_araddr == rre_pkg::RRE_OFS_ACC_B)
        rdata_d = {16'h0000, acc_b_q};
      else if (s_axi_araddr == rre_pkg::RRE_OFS_FLAGS)
        rdata_d = {30'h0, carry_q, ext_q};
      else if (s_axi_araddr == rre_pkg::RRE_OFS_PC)
        rdata_d = {16'h0000, pc_q};
      else if (s_axi_araddr == rre_pkg::RRE_OFS_MAR)
        rdata_d = {16'h0000, mar_q};
      else if (s_axi_araddr == rre_pkg::RRE_OFS_STAT)
        rdata_d = {busy_q, 9'h0, ir_q, tr_q};
      else
        rdata_d = 32'h00000000;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= rre_pkg::RRE_WORD_RST;
      wstrb_q   <= 2'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= rre_pkg::RRE_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= rre_pkg::RRE_RESP_OKAY;
      rdata_q   <= 32'h00000000;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign exec_busy     = busy_q;
  assign mem_addr      = mar_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Checks; racc_p_q holds last cycle's operand for them
  logic [15:0] racc_p_q;
  logic [15:0] acc_sel;
  always_ff @(posedge sys_clk)
    racc_p_q <= racc;
  assign acc_sel = tr_q[rre_pkg::RRE_TR_ACC_SEL] ? acc_b_q : acc_a_q;

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sr_t3;
    state_q == rre_pkg::RRE_T3 && is_rr && !grp_as && tr_q[rre_pkg::RRE_SR_EN1];
  endsequence
  sequence s_sr_t4;
    state_q == rre_pkg::RRE_T4 && is_rr && !grp_as;
  endsequence

  AST_PHASE_WALK: assert property (state_q == rre_pkg::RRE_T0 |-> ##3 state_q == rre_pkg::RRE_T3 ##3 state_q == rre_pkg::RRE_T6 ##1 state_q == rre_pkg::RRE_T7) // see (RL1)
    else $error("phase periods out of order");
  AST_ACC_QUIET: assert property ($changed(acc_a_q) |-> $past(state_q) == rre_pkg::RRE_T3 || $past(state_q) == rre_pkg::RRE_T4 || $past(state_q) == rre_pkg::RRE_T5 || $past(wr_do)) // see (RL1)
    else $error("accumulator A changed outside T3 to T5");
  AST_IR_LOAD: assert property (state_q == rre_pkg::RRE_T2 |=> ir_q == $past(tr_q[15:10]) && tr_q == $past(fetch_word, 2)) // see (RL2)
    else $error("instruction register not loaded from word");
  AST_CARRY_CLR: assert property (state_q == rre_pkg::RRE_T0 |=> !carry_q && tr_q == 16'h0000) // see (RL19)
    else $error("carry not cleared at phase start");
  AST_PC_STEP: assert property (state_q == rre_pkg::RRE_T7 |=> pc_q == $past(pc_q) + 16'h0001 + {15'h0, $past(carry_q)} && mar_q == pc_q) // see (RL3)
    else $error("program counter step wrong");
  AST_ALS: assert property (s_sr_t3 ##0 sif.shift_op == rre_pkg::RRE_ACCUM_ARITH_SHIFT_LEFT |=> acc_sel == {racc_p_q[15], racc_p_q[13:0], 1'b0}) // see (RL5)
    else $error("arithmetic left shift wrong");
  AST_ERA: assert property (s_sr_t3 ##0 sif.shift_op == rre_pkg::RRE_ROTATE_RIGHT_VIA_EXTEND |=> ext_q == racc_p_q[0] && acc_sel[15] == $past(ext_q)) // see (RL10)
    else $error("rotate through extend wrong");
  AST_ALF: assert property (s_sr_t3 ##0 sif.shift_op == rre_pkg::RRE_ACCUM_ROTATE_LEFT_FOUR |=> acc_sel == {racc_p_q[11:0], racc_p_q[15:12]}) // see (RL12)
    else $error("four place rotate wrong");
  AST_CLE: assert property (s_sr_t4 ##0 tr_q[rre_pkg::RRE_SR_CLE] |=> !ext_q) // see (RL13)
    else $error("extend not cleared");
  AST_SLA: assert property (s_sr_t4 ##0 tr_q[rre_pkg::RRE_SR_SLA] && !racc[0] |=> carry_q ##3 pc_q == $past(pc_q, 4) + 16'h0002) // see (RL14)
    else $error("lsb skip not taken");
  AST_CLA: assert property (state_q == rre_pkg::RRE_T3 && is_rr && grp_as && tr_q[rre_pkg::RRE_AS_ACC_LO +: 2] == rre_pkg::RRE_ALT_CLR |=> acc_sel == 16'h0000) // see (RL17)
    else $error("accumulator clear failed");

endmodule

//--- logic/rre_pkg.sv
// Constants and types of the register reference executor.
// Assumes a 16-bit machine word and registers reached over AXI4-Lite.
package rre_pkg;

  // Register byte offsets
  localparam logic [7:0]  RRE_OFS_ACC_A  = 8'h00;
  localparam logic [7:0]  RRE_OFS_ACC_B  = 8'h04;
  localparam logic [7:0]  RRE_OFS_FLAGS  = 8'h08;
  localparam logic [7:0]  RRE_OFS_PC     = 8'h0C;
  localparam logic [7:0]  RRE_OFS_MAR    = 8'h10;
  localparam logic [7:0]  RRE_OFS_STAT   = 8'h14;

  // Flag and status field positions
  localparam int          RRE_FLG_EXT    = 0;
  localparam int          RRE_FLG_CARRY  = 1;
  localparam int          RRE_STAT_BUSY  = 31;

  // Instruction word fields
  localparam int          RRE_TR_IR_LO   = 10;
  localparam int          RRE_TR_ACC_SEL = 11;
  localparam int          RRE_SR_EN1     = 9;
  localparam int          RRE_SR_OP1_LO  = 6;
  localparam int          RRE_SR_CLE     = 5;
  localparam int          RRE_SR_EN2     = 4;
  localparam int          RRE_SR_SLA     = 3;
  localparam int          RRE_SR_OP2_LO  = 0;
  localparam int          RRE_AS_ACC_LO  = 8;
  localparam int          RRE_AS_EXT_LO  = 6;
  localparam int          RRE_AS_SEZ     = 5;
  localparam int          RRE_AS_SSA     = 4;
  localparam int          RRE_AS_SLA     = 3;
  localparam int          RRE_AS_INC     = 2;
  localparam int          RRE_AS_SZA     = 1;
  localparam int          RRE_AS_RSS     = 0;
  localparam int          RRE_IR_GRP     = 0;
  localparam int          RRE_IR_TYPE_LO = 2;
  localparam logic [3:0]  RRE_IR_TYPE_RR = 4'h0;

  // Alter codes shared by accumulator and extend fields
  localparam logic [1:0]  RRE_ALT_CLR    = 2'h1;
  localparam logic [1:0]  RRE_ALT_CMP    = 2'h2;
  localparam logic [1:0]  RRE_ALT_BOTH   = 2'h3;

  // Reset values
  localparam logic [15:0] RRE_WORD_RST   = 16'h0000;
  localparam logic [5:0]  RRE_IR_RST     = 6'h00;
  localparam logic        RRE_BIT_RST    = 1'b0;

  // AXI responses
  localparam logic [1:0]  RRE_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RRE_RESP_SLVERR = 2'h2;

  typedef enum logic [8:0] {
    RRE_IDLE = 9'h001,
    RRE_T0   = 9'h002,
    RRE_T1   = 9'h004,
    RRE_T2   = 9'h008,
    RRE_T3   = 9'h010,
    RRE_T4   = 9'h020,
    RRE_T5   = 9'h040,
    RRE_T6   = 9'h080,
    RRE_T7   = 9'h100
  } rre_state_t;

  typedef enum logic [2:0] {
    RRE_ACCUM_ARITH_SHIFT_LEFT      = 3'h0,
    RRE_ACCUM_ARITH_SHIFT_RIGHT     = 3'h1,
    RRE_ACCUM_ROTATE_LEFT           = 3'h2,
    RRE_ACCUM_ROTATE_RIGHT          = 3'h3,
    RRE_ACCUM_SHIFT_LEFT_CLEAR_SIGN = 3'h4,
    RRE_ROTATE_RIGHT_VIA_EXTEND     = 3'h5,
    RRE_ROTATE_LEFT_VIA_EXTEND      = 3'h6,
    RRE_ACCUM_ROTATE_LEFT_FOUR      = 3'h7
  } rre_shop_t;

endpackage

//--- logic/rre_shift_if.sv
// Bundle between the executor and its shift network.
// Assumes both ends run in the executor's clock domain.
`timescale 1ns/1ps
interface rre_shift_if;
  logic [15:0]        first_operand_bus;
  logic [15:0]        result_bus;
  rre_pkg::rre_shop_t shift_op;
  logic               ext_in;
  logic               ext_out;

  modport exec (
    output first_operand_bus,
    output shift_op,
    output ext_in,
    input  result_bus,
    input  ext_out
  );

  modport net (
    input  first_operand_bus,
    input  shift_op,
    input  ext_in,
    output result_bus,
    output ext_out
  );
endinterface

//--- logic/rre_shift_net.sv
// Combinational shift and rotate network from operand bus to result bus.
// Assumes the executor stores the result and the new extend bit itself.
`timescale 1ns/1ps
module rre_shift_net (
  // Operand, function and result
  rre_shift_if.net sif
);

  logic [15:0] rb;

  assign rb = sif.first_operand_bus;

  always_comb
  begin
    sif.result_bus = 16'h0000;
    sif.ext_out    = sif.ext_in;
    case (sif.shift_op)
      rre_pkg::RRE_ACCUM_ARITH_SHIFT_LEFT:
        sif.result_bus = {rb[15], rb[13:0], 1'b0}; // see (RL5) (RL20)
      rre_pkg::RRE_ACCUM_ARITH_SHIFT_RIGHT:
        sif.result_bus = {rb[15], rb[15:1]}; // see (RL6)
      rre_pkg::RRE_ACCUM_ROTATE_LEFT:
        sif.result_bus = {rb[14:0], rb[15]}; // see (RL7)
      rre_pkg::RRE_ACCUM_ROTATE_RIGHT:
        sif.result_bus = {rb[0], rb[15:1]}; // see (RL8)
      rre_pkg::RRE_ACCUM_SHIFT_LEFT_CLEAR_SIGN:
        sif.result_bus = {1'b0, rb[13:0], 1'b0}; // see (RL9)
      rre_pkg::RRE_ROTATE_RIGHT_VIA_EXTEND:
      begin
        sif.result_bus = {sif.ext_in, rb[15:1]}; // see (RL10)
        sif.ext_out    = rb[0];
      end
      rre_pkg::RRE_ROTATE_LEFT_VIA_EXTEND:
      begin
        sif.result_bus = {rb[14:0], sif.ext_in}; // see (RL11)
        sif.ext_out    = rb[15];
      end
      rre_pkg::RRE_ACCUM_ROTATE_LEFT_FOUR:
        sif.result_bus = {rb[11:0], rb[15:12]}; // see (RL12)
    endcase
  end

endmodule
